// ==== hw/conv_mode_pkg.sv ====
/*
  Package for the converter mode and pin control block: control word layout,
  reset values, timing counts, status layout and the trim sequencer states.
  Assumes a single 250 MHz reference clock.
*/
`default_nettype none
package conv_mode_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_PS      = 4000;
  localparam int unsigned WAIT_LONG_NS       = 100000;
  localparam int unsigned WAIT_SHORT_NS      = 10000;
  localparam int unsigned WAIT_LONG_CYC      = (WAIT_LONG_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned WAIT_SHORT_CYC     = (WAIT_SHORT_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned TRIG_LOW_NS        = 80;
  localparam int unsigned TRIG_HIGH_NS       = 80;
  localparam int unsigned TRIG_LOW_CYC       = (TRIG_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned TRIG_HIGH_CYC      = (TRIG_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned TRIM_RUN_NS        = 4000;
  localparam int unsigned TRIM_RUN_CYC       = (TRIM_RUN_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned PWRUP_NS           = 400;
  localparam int unsigned PWRUP_CYC          = (PWRUP_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W              = 16;

  // ****************************************************************
  // Registers
  // ****************************************************************
  localparam logic [3:0]  ADDR_CTRL          = 4'h0;
  localparam logic [3:0]  ADDR_STATUS        = 4'h1;
  localparam logic [3:0]  ADDR_IRQ_MASK      = 4'h2;
  localparam logic [3:0]  ADDR_EXT_MODE      = 4'h3;
  localparam int unsigned BIT_INTERLEAVE     = 7;
  localparam int unsigned BIT_Q_POWERDOWN    = 10;
  localparam int unsigned BIT_I_POWERDOWN    = 11;
  localparam int unsigned BIT_PATTERN        = 12;
  localparam int unsigned BIT_TRIM_TRIGGER   = 15;
  localparam logic [15:0] CTRL_RESET         = 16'h0000;
  localparam logic [15:0] CTRL_WMASK         = 16'h9c80;
  localparam logic [2:0]  MASK_RESET         = 3'h0;
  localparam logic        EXT_MODE_RESET     = 1'b0;
  localparam int unsigned ST_TRIM_DONE       = 0;
  localparam int unsigned ST_I_READY         = 1;
  localparam int unsigned ST_Q_READY         = 2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic ext_mode_enable_n;
    logic dual_edge_select;
    logic self_trim_wait_select;
    logic self_trim_trigger;
    logic i_channel_powerdown;
    logic q_channel_powerdown;
    logic pattern_output_select;
    logic output_unsplit_select;
  } pins_t;

  typedef struct packed {
    logic interleaved;
    logic i_powerdown;
    logic q_powerdown;
    logic pattern;
    logic unsplit;
  } mode_t;

  typedef enum logic [1:0] {
    TRIM_WAIT = 2'b00,
    TRIM_IDLE = 2'b01,
    TRIM_RUN  = 2'b10,
    TRIM_HOLD = 2'b11
  } trim_state_t;

endpackage : conv_mode_pkg
`default_nettype wire

// ==== hw/pin_sync.sv ====
/*
  Two-flop synchroniser for a bundle of control pins.
  Assumes the pins are asynchronous to i_ref_clk.
*/
`default_nettype none
module pin_sync
  import conv_mode_pkg::*;
(
  input  wire logic  i_ref_clk,
  input  wire logic  i_reset_n,
  input  wire pins_t i_pins,
  output var  pins_t o_pins
);

  pins_t meta_q;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      // Reset to strap mode so no false extended mode follows reset
      meta_q <= '{ext_mode_enable_n: 1'b1, default: 1'b0};
      o_pins <= '{ext_mode_enable_n: 1'b1, default: 1'b0};
    end else begin
      meta_q <= i_pins;
      o_pins <= meta_q;
    end
  end

endmodule : pin_sync
`default_nettype wire

// ==== hw/converter_mode_pin_control.sv ====
/*
  Mode and control logic of a dual-channel converter: interleave select,
  self-trim sequencing, per-channel power-down, pattern and output split
  selects, from strap pins or control word. Assumes asynchronous pins and a
  simple one-cycle register port driven from the i_ref_clk domain.
*/
// Function
// RQ1 - Strap mode, interleave high: both channels sample I input, Q ignored.
// RQ2 - Strap mode, interleave low: I and Q run as independent converters.
// RQ3 - Extended mode ignores interleave pin, uses control bit 7, default independent.
// RQ4 - Wait select high gives long power-on trim wait, low gives short.
// RQ5 - Trigger low for minimum, then high for minimum, runs one trim.
// RQ6 - Trigger high at power-on withholds automatic trim until cycled low-high.
// RQ7 - Extended mode ORs trigger with bit 15; both low before rise counts.
// RQ8 - Trim active output high exactly while a trim sequence runs.
// RQ9 - Power-down high stops channel; low restores after finite delay.
// RQ10 - Extended mode ORs I power-down with bit 11, Q with bit 10.
// RQ11 - Strap mode, pattern pin high: fixed repeating test pattern output.
// RQ12 - Extended mode ignores pattern pin, uses control bit 12 only.
// RQ13 - Unsplit pin high selects 1:1 bus, low selects 1:2, any mode.
// RQ14 - Enable_n low enters extended mode; high resets control word, follows pins.
// RQ15 - Pins synchronised; trigger sequence detected on synchronised level only.
`default_nettype none
module converter_mode_pin_control
  import conv_mode_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  input  wire pins_t       i_pins,
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output var  logic [15:0] o_rdata,
  output var  mode_t       o_mode,
  output var  logic        o_self_trim_active,
  output var  logic [9:0]  o_pattern_word,
  output var  logic        o_irq
);

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  pins_t pins_s;

  pin_sync u_pin_sync (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_pins    (i_pins),
    .o_pins    (pins_s)   // RQ15
  );

  // ****************************************************************
  // Control word and register port
  // ****************************************************************
  logic [15:0] ctrl_q;
  logic [2:0]  status_q;
  logic [2:0]  mask_q;
  logic [2:0]  events;
  logic        ext_mode;
  logic        wr_ctrl;
  logic        wr_mask;
  logic        rd_status;
  logic [15:0] rdata_d;

  assign ext_mode  = !pins_s.ext_mode_enable_n;          // RQ14
  assign wr_ctrl   = i_wr && (i_addr == ADDR_CTRL) && ext_mode;
  assign wr_mask   = i_wr && (i_addr == ADDR_IRQ_MASK);
  assign rd_status = i_rd && (i_addr == ADDR_STATUS);

  always_comb begin
    case (i_addr)
      ADDR_CTRL:     rdata_d = ctrl_q;
      ADDR_STATUS:   rdata_d = {13'h0000, status_q};
      ADDR_IRQ_MASK: rdata_d = {13'h0000, mask_q};
      ADDR_EXT_MODE: rdata_d = {15'h0000, ext_mode};
      default:       rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_q <= CTRL_RESET;
    end else if (!ext_mode) begin
      ctrl_q <= CTRL_RESET;                              // RQ14
    end else if (wr_ctrl) begin
      ctrl_q <= i_wdata & CTRL_WMASK;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata  <= 16'h0000;
      mask_q   <= MASK_RESET;
      status_q <= 3'h0;
    end else begin
      o_rdata  <= i_rd ? rdata_d : 16'h0000;
      if (wr_mask) begin
        mask_q <= i_wdata[2:0];
      end
      // Set wins over read-clear
      status_q <= (rd_status ? 3'h0 : status_q) | events;
    end
  end

  assign o_irq = |(status_q & mask_q);

  // ****************************************************************
  // Mode selection
  // ****************************************************************
  logic i_pd_req;
  logic q_pd_req;
  logic trig_level;

  assign trig_level = pins_s.self_trim_trigger | (ext_mode & ctrl_q[BIT_TRIM_TRIGGER]); // RQ7
  assign i_pd_req   = pins_s.i_channel_powerdown | (ext_mode & ctrl_q[BIT_I_POWERDOWN]); // RQ9 RQ10
  assign q_pd_req   = pins_s.q_channel_powerdown | (ext_mode & ctrl_q[BIT_Q_POWERDOWN]); // RQ9 RQ10

  mode_t mode_d;
  always_comb begin
    mode_d.interleaved = ext_mode ? ctrl_q[BIT_INTERLEAVE] : pins_s.dual_edge_select;    // RQ1 RQ2 RQ3
    mode_d.pattern     = ext_mode ? ctrl_q[BIT_PATTERN] : pins_s.pattern_output_select;  // RQ11 RQ12
    mode_d.unsplit     = pins_s.output_unsplit_select;                                   // RQ13
    mode_d.i_powerdown = i_pd_req;
    mode_d.q_powerdown = q_pd_req;
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_mode <= '0;
    end else begin
      o_mode <= mode_d;
    end
  end

  // ****************************************************************
  // Channel power-up delay
  // ****************************************************************
  logic [CNT_W-1:0] i_up_q;
  logic [CNT_W-1:0] q_up_q;
  logic             i_ready;
  logic             q_ready;
  logic             i_ready_q;
  logic             q_ready_q;

  assign i_ready = (i_up_q == CNT_W'(PWRUP_CYC));
  assign q_ready = (q_up_q == CNT_W'(PWRUP_CYC));

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      i_up_q    <= '0;
      q_up_q    <= '0;
      i_ready_q <= 1'b0;
      q_ready_q <= 1'b0;
    end else begin
      i_up_q    <= i_pd_req ? '0 : (i_ready ? i_up_q : i_up_q + 1'b1);  // RQ9
      q_up_q    <= q_pd_req ? '0 : (q_ready ? q_up_q : q_up_q + 1'b1);  // RQ9
      i_ready_q <= i_ready;
      q_ready_q <= q_ready;
    end
  end

  // ****************************************************************
  // Test pattern
  // ****************************************************************
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pattern_word <= 10'h000;
    end else if (mode_d.pattern) begin
      o_pattern_word <= ~o_pattern_word;                 // RQ11
    end else begin
      o_pattern_word <= 10'h000;
    end
  end

  // ****************************************************************
  // Self-trim sequencer
  // ****************************************************************
  trim_state_t      state_q;
  trim_state_t      state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] low_cnt_q;
  logic [CNT_W-1:0] high_cnt_q;
  logic             armed_q;
  logic [2:0]       settle_q;
  logic             first_valid;
  logic             low_ok;
  logic             cmd_start;
  logic [CNT_W-1:0] wait_cyc;
  logic             trim_done;

  assign low_ok    = (low_cnt_q == CNT_W'(TRIG_LOW_CYC));
  assign cmd_start = armed_q && trig_level && (high_cnt_q == CNT_W'(TRIG_HIGH_CYC - 1)); // RQ5 RQ15
  assign wait_cyc  = pins_s.self_trim_wait_select ? CNT_W'(WAIT_LONG_CYC) : CNT_W'(WAIT_SHORT_CYC); // RQ4
  assign trim_done = (state_q == TRIM_RUN) && (cnt_q == CNT_W'(TRIM_RUN_CYC - 1));
  // Synchronised pins are first valid two edges after reset
  assign first_valid = (settle_q == 3'b011);

  always_comb begin
    state_d = state_q;
    case (state_q)
      TRIM_WAIT: if (first_valid && trig_level) state_d = TRIM_HOLD;  // RQ6
                 else if (cnt_q >= wait_cyc) state_d = TRIM_RUN;      // RQ4
      TRIM_HOLD: if (cmd_start) state_d = TRIM_RUN;                  // RQ6
      TRIM_IDLE: if (cmd_start) state_d = TRIM_RUN;                  // RQ5
      TRIM_RUN:  if (trim_done) state_d = TRIM_IDLE;
      default:   state_d = TRIM_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q    <= TRIM_WAIT;
      cnt_q      <= '0;
      settle_q   <= 3'b000;
      low_cnt_q  <= '0;
      high_cnt_q <= '0;
      armed_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      settle_q <= {settle_q[1:0], 1'b1};
      cnt_q   <= (state_d != state_q) ? '0 : cnt_q + 1'b1;
      if (!trig_level) begin
        low_cnt_q  <= low_ok ? low_cnt_q : low_cnt_q + 1'b1;          // RQ7
        high_cnt_q <= '0;
        armed_q    <= low_ok;
      end else begin
        low_cnt_q  <= '0;
        high_cnt_q <= cmd_start ? high_cnt_q : high_cnt_q + 1'b1;
        armed_q    <= armed_q && !cmd_start;
      end
    end
  end

  assign o_self_trim_active = (state_q == TRIM_RUN);    // RQ8
  assign events = {q_ready && !q_ready_q, i_ready && !i_ready_q, trim_done};

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_ext_ignores_pin: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ3
    ext_mode |=> o_mode.interleaved == $past(ctrl_q[BIT_INTERLEAVE]))
    else $error("interleave not from control bit");
  a_strap_interleave: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ1
    !ext_mode |=> o_mode.interleaved == $past(pins_s.dual_edge_select))
    else $error("interleave not from pin");
  a_pattern_select: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ12
    ext_mode && !ctrl_q[BIT_PATTERN] |=> !o_mode.pattern)
    else $error("pattern active without bit");
  a_unsplit_follow: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ13
    1'b1 |=> o_mode.unsplit == $past(pins_s.output_unsplit_select))
    else $error("unsplit not following pin");
  a_pd_or: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ10
    ext_mode && ctrl_q[BIT_I_POWERDOWN] |=> o_mode.i_powerdown)
    else $error("I power-down bit ignored");
  a_ctrl_reset: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ14
    !ext_mode |=> ctrl_q == CTRL_RESET)
    else $error("control word not reset");
  a_trim_no_start: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ5
    (state_q == TRIM_IDLE) && !armed_q |=> state_q != TRIM_RUN)
    else $error("trim started without low phase");
  a_trim_active: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ8
    $rose(o_self_trim_active) |-> o_self_trim_active [*8])
    else $error("trim active dropped early");
  a_trim_full_run: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ8
    $fell(o_self_trim_active) |-> $past(cnt_q) == CNT_W'(TRIM_RUN_CYC - 1))
    else $error("trim active ended before full run");
  a_hold_power_on: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ6
    (state_q == TRIM_HOLD) && !cmd_start |=> state_q == TRIM_HOLD)
    else $error("held trim released without trigger");
  a_pd_stops: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ9
    i_pd_req |=> !i_ready)
    else $error("I channel ready while powered down");
  a_ready_delay: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ9
    $rose(i_ready) |-> $past(i_up_q) == CNT_W'(PWRUP_CYC - 1))
    else $error("I channel ready without power-up delay");
  a_strap_pd: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ9
    !ext_mode |=> o_mode.i_powerdown == $past(pins_s.i_channel_powerdown))
    else $error("I power-down not following pin");
  a_q_pd_or: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ10
    ext_mode && ctrl_q[BIT_Q_POWERDOWN] |=> o_mode.q_powerdown)
    else $error("Q power-down bit ignored");
  a_strap_pattern: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ11
    !ext_mode |=> o_mode.pattern == $past(pins_s.pattern_output_select))
    else $error("pattern not following pin");
  a_pattern_toggle: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ11
    mode_d.pattern |=> o_pattern_word == ~$past(o_pattern_word))
    else $error("pattern word not repeating");
  a_power_on_hold: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ6
    first_valid && trig_level && (state_q == TRIM_WAIT) |=> state_q == TRIM_HOLD)
    else $error("power-on trim not withheld");
  a_wait_select: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RQ4
    (state_q == TRIM_WAIT) && (cnt_q < wait_cyc) |=> state_q != TRIM_RUN)
    else $error("power-on trim started before wait");

  c_power_on_trim: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (state_q == TRIM_WAIT) ##1 (state_q == TRIM_RUN));
  c_cmd_trim: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (state_q == TRIM_IDLE) && cmd_start);
  c_ext_interleave: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    ext_mode && o_mode.interleaved);
  c_irq: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) o_irq);

endmodule : converter_mode_pin_control
`default_nettype wire

// ==== test/pin_ctl_model.sv ====
/*
  Controller model that drives the converter strap pins.
  Assumes the bench calls its tasks from the i_ref_clk domain.
*/
`default_nettype none
module pin_ctl_model
  import conv_mode_pkg::*;
(
  input  wire logic  i_ref_clk,
  output var  pins_t o_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Pin driving
  // ****************************************************************
  initial o_pins = '{ext_mode_enable_n: 1'b1, self_trim_trigger: 1'b1, default: 1'b0};
  task automatic put(input pins_t v);
    @(posedge i_ref_clk);
    o_pins <= v;
  endtask : put
  // Trigger low past its minimum, then left high
  task automatic trigger_cycle();
    pins_t v;
    v = o_pins;
    v.self_trim_trigger = 1'b0;
    put(v);
    repeat (TRIG_LOW_CYC + 4) @(posedge i_ref_clk);
    v.self_trim_trigger = 1'b1;
    put(v);
  endtask : trigger_cycle
endmodule : pin_ctl_model
`default_nettype wire

// ==== test/converter_mode_pin_control_bench.sv ====
/*
  Self-checking bench for the converter mode and pin control block.
  Assumes pin_ctl_model drives the pins and a 250 MHz clock.
*/
`default_nettype none
module converter_mode_pin_control_bench;
  import conv_mode_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_ref_clk;
  logic        i_reset_n;
  pins_t       pins;
  logic [3:0]  i_addr;
  logic [15:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [15:0] o_rdata;
  mode_t       o_mode;
  logic        o_self_trim_active;
  logic [9:0]  o_pattern_word;
  logic        o_irq;
  int          err_total;
  int          comparisons;

  pin_ctl_model ctl (.i_ref_clk(i_ref_clk), .o_pins(pins));
  converter_mode_pin_control dut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_pins(pins),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_mode(o_mode),
    .o_self_trim_active(o_self_trim_active), .o_pattern_word(o_pattern_word), .o_irq(o_irq));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd
  task automatic do_reset();
    @(posedge i_ref_clk);
    i_reset_n <= 1'b0;
    repeat (8) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
  endtask : do_reset
  // Waits for a trim to start, then measures how long it runs
  task automatic run_trim(output int len);
    int n;
    for (n = 0; n < 200 && o_self_trim_active !== 1'b1; n++) @(posedge i_ref_clk);
    if (n == 200) begin
      err_total++;
      close_out();
    end
    for (len = 0; len < 2000 && o_self_trim_active === 1'b1; len++) @(posedge i_ref_clk);
  endtask : run_trim

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_hold_trim();
    int seen;
    int len;
    logic [15:0] d;
    seen = 0;
    repeat (WAIT_SHORT_CYC + 500) begin
      @(posedge i_ref_clk);
      if (o_self_trim_active !== 1'b0) seen++;
    end
    chk("held power-on trim", 16'(seen), 16'h0000);
    wr(ADDR_IRQ_MASK, 16'h0001);
    ctl.trigger_cycle();
    run_trim(len);
    chk("trim length", 16'(len), 16'(TRIM_RUN_CYC));
    repeat (3) @(posedge i_ref_clk);
    chk("irq after trim", 16'(o_irq), 16'h0001);
    rd(ADDR_STATUS, d);
    chk("trim done flag", 16'(d[ST_TRIM_DONE]), 16'h0001);
    @(negedge i_ref_clk);
    chk("irq cleared", 16'(o_irq), 16'h0000);
  endtask : t_hold_trim
  task automatic t_strap();
    logic [4:0] f;
    logic [9:0] w0;
    logic [15:0] d;
    for (int i = 0; i < 4; i++) begin
      f = (i == 0) ? 5'h15 : (i == 1) ? 5'h0a : (i == 2) ? 5'h1f : 5'h00;
      ctl.put('{ext_mode_enable_n: 1'b1, dual_edge_select: f[4], i_channel_powerdown: f[3],
        q_channel_powerdown: f[2], pattern_output_select: f[1], output_unsplit_select: f[0], default: 1'b0});
      repeat (6) @(posedge i_ref_clk);
      #1 chk("strap mode", 16'(o_mode), 16'(f));
      w0 = o_pattern_word;
      @(posedge i_ref_clk);
      #1 chk("pattern step", 16'(w0 ^ o_pattern_word), f[1] ? 16'h03ff : 16'h0000);
      chk("pattern value", 16'(w0 == 10'h000 || w0 == 10'h3ff), 16'h0001);
    end
    rd(ADDR_STATUS, d);
    chk("channels not yet ready", 16'(d[ST_Q_READY:ST_I_READY]), 16'h0000);
    repeat (PWRUP_CYC + 10) @(posedge i_ref_clk);
    rd(ADDR_STATUS, d);
    chk("channels ready", 16'(d[ST_Q_READY:ST_I_READY]), 16'h0003);
  endtask : t_strap
  task automatic t_ext();
    logic [15:0] d;
    int len;
    ctl.put('{dual_edge_select: 1'b1, q_channel_powerdown: 1'b1, pattern_output_select: 1'b1,
      output_unsplit_select: 1'b1, default: 1'b0});
    repeat (30) @(posedge i_ref_clk);
    rd(ADDR_EXT_MODE, d);
    chk("extended flag", d, 16'h0001);
    wr(ADDR_CTRL, 16'h7fff);
    rd(ADDR_CTRL, d);
    chk("control word", d, 16'h1c80);
    chk("ext mode bits", 16'(o_mode), 16'h001f);
    wr(ADDR_CTRL, 16'h0000);
    repeat (2) @(posedge i_ref_clk);
    chk("ext mode pins", 16'(o_mode), 16'h0005);
    wr(ADDR_CTRL, 16'h8000);
    run_trim(len);
    chk("bit trim length", 16'(len), 16'(TRIM_RUN_CYC));
    wr(ADDR_CTRL, 16'h0000);
    rd(4'hf, d);
    chk("unmapped read", d, 16'h0000);
    ctl.put('{ext_mode_enable_n: 1'b1, dual_edge_select: 1'b1, q_channel_powerdown: 1'b1,
      pattern_output_select: 1'b1, output_unsplit_select: 1'b1, default: 1'b0});
    repeat (6) @(posedge i_ref_clk);
    wr(ADDR_CTRL, 16'h1c80);
    rd(ADDR_CTRL, d);
    chk("word in strap", d, 16'h0000);
    chk("strap restored", 16'(o_mode), 16'h0017);
  endtask : t_ext
  task automatic t_power_on(input logic wsel, input int unsigned wcyc);
    int unsigned n;
    ctl.put('{ext_mode_enable_n: 1'b1, self_trim_wait_select: wsel, default: 1'b0});
    do_reset();
    for (n = 0; n < wcyc + 100 && o_self_trim_active !== 1'b1; n++) @(posedge i_ref_clk);
    chk("power-on wait", 16'(n >= wcyc && n < wcyc + 50), 16'h0001);
  endtask : t_power_on

  initial begin
    i_reset_n = 1'b0;
    i_addr = 4'h0;
    i_wdata = 16'h0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    err_total = 0;
    comparisons = 0;
    do_reset();
    t_hold_trim();
    t_strap();
    t_ext();
    t_power_on(1'b0, WAIT_SHORT_CYC);
    t_power_on(1'b1, WAIT_LONG_CYC);
    close_out();
  end
endmodule : converter_mode_pin_control_bench
`default_nettype wire
